// file: include/master_clock_generator_regs.svh
// Register offsets, field positions, reset values and loop limits
`ifndef MASTER_CLOCK_GENERATOR_REGS_SVH
`define MASTER_CLOCK_GENERATOR_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CLOCK_GENERATION_CONTROL_OFS 32'h0000_0000
`define CLOCK_STATUS_OFS 32'h0000_0004

// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define CTL_MODE_LSB 0
`define CTL_IDIV_LSB 2
`define CTL_ODIV_LSB 4
`define CTL_MUL_LSB 8
`define CTL_BAND_LSB 13
`define CTL_HALVE_BIT 15
`define CTL_WIDTH 16

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define STS_LOCKED_BIT 0
`define STS_PLL_BIT 1
`define STS_MC_BIT 2
`define STS_PENDING_BIT 3
`define STS_BAND_LSB 4

// ----------------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------------
`define CTL_RST 16'h0000
`define MODE_PLL 2'h3
`define ODIV_MAX 4'he
`define IDIV_MAX 2'h3

// ----------------------------------------------------------------------
// Oscillator-loop step limits per band (fraction of ref_clk, 16 bits)
// ----------------------------------------------------------------------
`define BAND0_LO 16'h1000
`define BAND0_HI 16'h4000
`define BAND1_LO 16'h4000
`define BAND1_HI 16'h8000
`define BAND2_LO 16'h8000
`define BAND2_HI 16'hc000

`endif

// file: include/master_clock_generator_pkg.sv
// Types shared by the master clock generator
package master_clock_generator_pkg;

  // Layout equals the control register, bit 15 down to bit 0
  typedef struct packed {
    logic cpu_clock_halve;
    logic [1:0] oscillator_band_select;
    logic [4:0] loop_multiplier;
    logic [3:0] output_divider;
    logic [1:0] input_divider;
    logic [1:0] clock_mode_select;
  } cfg_t;

  typedef struct packed {
    logic [2:0] sync;
    logic osc;
    logic src;
    logic [1:0] icnt;
    logic [3:0] ocnt;
    logic mc;
    logic cpu;
    logic sys;
    logic [15:0] acc;
    logic [15:0] step;
    logic [7:0] vcnt;
    logic locked;
    cfg_t cfg;
    cfg_t shadow;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

endpackage : master_clock_generator_pkg

// file: logic/master_clock_generator.sv
// Master clock generator with bypass prescalers and digital loop
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "master_clock_generator_regs.svh"

module master_clock_generator
  import master_clock_generator_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic osc_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic master_clk,
  output logic cpu_clk,
  output logic sys_clk,
  output logic [1:0] oscillator_band_select,
  output logic pll_locked
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic reg_hit(input logic [31:0] a,
                                   input logic [31:0] ofs);
    reg_hit = (a[31:2] == ofs[31:2]);
  endfunction : reg_hit

  function automatic logic [15:0] band_lo(input logic [1:0] b);
    case (b)
      2'h0: band_lo = `BAND0_LO;
      2'h1: band_lo = `BAND1_LO;
      default: band_lo = `BAND2_LO;
    endcase
  endfunction : band_lo

  function automatic logic [15:0] band_hi(input logic [1:0] b);
    case (b)
      2'h0: band_hi = `BAND0_HI;
      2'h1: band_hi = `BAND1_HI;
      default: band_hi = `BAND2_HI;
    endcase
  endfunction : band_hi

  state_t s_q;
  state_t s_d;
  logic osc_edge;
  logic src_edge;
  logic pll;
  logic tick;
  logic ev;
  logic [7:0] target;
  logic [15:0] lo;
  logic [15:0] hi;
  cfg_t wcfg;

  // Step starts inside the lowest band so no out-of-range value is held
  localparam state_t rst_state = '{step: `BAND0_LO, default: '0};

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    src_edge = 1'b0;
    // Three-stage input; level moves once stages two and three agree
    s_d.sync = {s_q.sync[1:0], osc_in};
    if (s_q.sync[1] == s_q.sync[2]) begin
      s_d.osc = s_q.sync[2];
    end
    osc_edge = (s_d.osc != s_q.osc);
    pll = (s_q.cfg.clock_mode_select == `MODE_PLL);

    // Input prescaler counts oscillator edges
    if (osc_edge) begin
      if (s_q.icnt >= s_q.cfg.input_divider) begin
        s_d.icnt = 2'h0;
        s_d.src = ~s_q.src;
        src_edge = 1'b1;
      end else begin
        s_d.icnt = s_q.icnt + 2'h1;
      end
    end

    // Oscillator loop: phase accumulator, carry is one edge
    {tick, s_d.acc} = {1'b0, s_q.acc} + {1'b0, s_q.step};
    target = {2'h0, s_q.cfg.loop_multiplier, 1'b0} + 8'h2;
    lo = band_lo(s_q.cfg.oscillator_band_select);
    hi = band_hi(s_q.cfg.oscillator_band_select);
    if (!pll) begin
      s_d.step = lo;
      s_d.vcnt = 8'h0;
      s_d.locked = 1'b0;
    end else begin
      if (tick && s_q.vcnt != 8'hff) begin
        s_d.vcnt = s_q.vcnt + 8'h1;
      end
      if (src_edge && s_d.src) begin
        // One step per reference period keeps the slew smooth
        if (s_q.vcnt < target && s_q.step < hi) begin
          s_d.step = s_q.step + 16'h1;
        end else if (s_q.vcnt > target && s_q.step > lo) begin
          s_d.step = s_q.step - 16'h1;
        end
        s_d.locked = (s_q.vcnt == target);
        // Edge in the boundary cycle opens the next window
        s_d.vcnt = tick ? 8'h1 : 8'h0;
      end
    end

    // Output prescaler, shared by both modes
    ev = pll ? tick : src_edge;
    if (ev) begin
      if (s_q.ocnt >= s_q.cfg.output_divider) begin
        s_d.ocnt = 4'h0;
        s_d.mc = ~s_q.mc;
        if (s_d.mc) begin
          s_d.cfg = s_q.shadow;
        end
      end else begin
        s_d.ocnt = s_q.ocnt + 4'h1;
      end
    end

    // New band applies with the step pulled into its range
    if (s_d.cfg != s_q.cfg) begin
      if (s_d.step < band_lo(s_d.cfg.oscillator_band_select)) begin
        s_d.step = band_lo(s_d.cfg.oscillator_band_select);
      end else if (s_d.step > band_hi(s_d.cfg.oscillator_band_select)) begin
        s_d.step = band_hi(s_d.cfg.oscillator_band_select);
      end
    end

    // CPU and system clocks
    if (!s_d.cfg.cpu_clock_halve) begin
      s_d.cpu = s_d.mc;
    end else if (s_d.mc && !s_q.mc) begin
      s_d.cpu = ~s_q.cpu;
    end
    s_d.sys = s_d.cpu;

    // APB slave, one wait state
    wcfg = cfg_t'(pwdata[`CTL_WIDTH-1:0]);
    if (wcfg.output_divider > `ODIV_MAX) begin
      wcfg.output_divider = `ODIV_MAX;
    end
    s_d.pready = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (s_d.pready) begin
      s_d.prdata = 32'h0;
      s_d.pslverr = !reg_hit(paddr, `CLOCK_GENERATION_CONTROL_OFS) &&
                    !reg_hit(paddr, `CLOCK_STATUS_OFS);
      if (reg_hit(paddr, `CLOCK_GENERATION_CONTROL_OFS)) begin
        s_d.prdata[`CTL_WIDTH-1:0] = s_q.shadow;
        if (pwrite) begin
          s_d.shadow = wcfg;
        end
      end else if (reg_hit(paddr, `CLOCK_STATUS_OFS) && !pwrite) begin
        s_d.prdata[`STS_LOCKED_BIT] = s_q.locked;
        s_d.prdata[`STS_PLL_BIT] = pll;
        s_d.prdata[`STS_MC_BIT] = s_q.mc;
        s_d.prdata[`STS_PENDING_BIT] = (s_q.shadow != s_q.cfg);
        s_d.prdata[`STS_BAND_LSB +: 2] = s_q.cfg.oscillator_band_select;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= rst_state;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign master_clk = s_q.mc;
  assign cpu_clk = s_q.cpu;
  assign sys_clk = s_q.sys;
  assign oscillator_band_select = s_q.cfg.oscillator_band_select;
  assign pll_locked = s_q.locked;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  bypass_edge_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.cfg.clock_mode_select[1] == 1'b0 && $stable(s_q.cfg) &&
     $changed(s_q.mc)) |-> $changed(s_q.osc))
    else $error("bypass master clock moved without oscillator edge");

  direct_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!pll && s_q.cfg.input_divider == 2'h0 &&
     s_q.cfg.output_divider == 4'h0 && $changed(s_d.osc)) |=>
    $changed(s_q.mc))
    else $error("master clock not following oscillator");

  odiv_limit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.shadow.output_divider <= `ODIV_MAX)
    else $error("output divider above limit");

  loop_tick_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pll && $changed(s_d.mc)) |-> tick)
    else $error("loop master clock moved without loop edge");

  step_band_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.step >= band_lo(s_q.cfg.oscillator_band_select) &&
    s_q.step <= band_hi(s_q.cfg.oscillator_band_select) ||
    $changed(s_q.cfg))
    else $error("loop step outside band");

  step_slew_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (pll && $past(pll) && $stable(s_q.cfg)) |->
    (s_q.step == $past(s_q.step) || s_q.step == $past(s_q.step) + 16'h1 ||
     s_q.step == $past(s_q.step) - 16'h1))
    else $error("loop step jumped");

  cpu_half_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (s_q.cfg.cpu_clock_halve && $stable(s_q.cfg) && $rose(s_q.mc)) |->
    s_q.cpu != $past(s_q.cpu))
    else $error("halved cpu clock missed a toggle");

  cpu_full_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !s_q.cfg.cpu_clock_halve |-> s_q.cpu == s_q.mc)
    else $error("cpu clock differs from master clock");

  sys_cpu_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    s_q.sys == s_q.cpu)
    else $error("system clock differs from cpu clock");

  cfg_boundary_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $changed(s_q.cfg) |-> $rose(s_q.mc))
    else $error("configuration changed inside a period");

  apb_ready_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (psel && penable && !s_q.pready) |=> s_q.pready ##1 !s_q.pready)
    else $error("apb answer not one wait state");

endmodule : master_clock_generator

// file: tb/master_clock_generator_bench.sv
// Self-checking bench for the master clock generator
`timescale 1ns/1ps
`include "master_clock_generator_regs.svh"
module master_clock_generator_bench
  import master_clock_generator_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic osc_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, master_clk, cpu_clk, sys_clk, pll_locked;
  logic [1:0] oscillator_band_select;
  logic [2:0] oc = 3'h0;
  int bad_count = 0;
  int n_checks = 0;

  master_clock_generator u_master_clock_generator (.ref_clk(ref_clk),
    .nrst(nrst), .osc_in(osc_in), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .master_clk(master_clk),
    .cpu_clk(cpu_clk), .sys_clk(sys_clk),
    .oscillator_band_select(oscillator_band_select),
    .pll_locked(pll_locked));

  // ----------------------------------------------------------------
  // Clocks: oscillator period is 8 ref_clk cycles
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    oc <= oc + 3'h1;
    osc_in <= oc[2];
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) bad_count++;
    @(posedge ref_clk);
  endtask : apb

  // Ref cycles between the 2nd and 3rd rise; 0 if it stalls
  task automatic period(input bit sel, output int p);
    int r, c, t;
    logic prev, cur;
    r = 0;
    c = 0;
    t = 0;
    p = 0;
    prev = sel ? cpu_clk : master_clk;
    while (r < 3 && c < 4000) begin
      @(posedge ref_clk);
      c++;
      cur = sel ? cpu_clk : master_clk;
      if (cur === 1'b1 && prev === 1'b0) begin
        r++;
        if (r == 3) p = c - t;
        t = c;
      end
      prev = cur;
    end
  endtask : period

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  always @(negedge ref_clk) begin
    if (nrst && sys_clk !== cpu_clk) chk({31'h0, sys_clk}, 32'h1);
  end

  initial begin
    #400_000;
    bad_count++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] seed, rd, ctl;
    logic err;
    logic [5:0] v;
    logic [1:0] i, m;
    logic [3:0] o, o2;
    int p, k;
    seed = 32'h20a1;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, 32'h0, 32'h0, rd, err);
    chk(rd, 32'h0);
    apb(1'b0, 32'h4, 32'h0, rd, err);
    chk(rd & 32'h3, 32'h0);
    apb(1'b0, 32'h10, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 32'h4, 32'hffff, rd, err);
    chk({31'h0, err}, 32'h0);
    $display("test reset and map done");
    for (k = 0; k < 7; k++) begin
      seed = lfsr(seed);
      v = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : (k == 2) ? 6'h04 : seed[5:0];
      m = (k == 6) ? 2'h2 : {1'b0, seed[8]};
      i = v[1:0];
      o = v[5:2];
      o2 = (o == 4'hf) ? 4'he : o;
      apb(1'b1, 32'h0, {24'h0, o, i, m}, rd, err);
      apb(1'b0, 32'h0, 32'h0, rd, err);
      chk(rd, {24'h0, o2, i, m});
      period(1'b0, p);
      chk(p, 8 * (i + 1) * (o2 + 1));
      apb(1'b0, 32'h4, 32'h0, rd, err);
      chk(rd & 32'h2, 32'h0);
      chk({31'h0, pll_locked}, 32'h0);
    end
    $display("test bypass dividers done");
    ctl = 32'h0000_8024;
    apb(1'b1, 32'h0, ctl, rd, err);
    period(1'b0, p);
    period(1'b0, p);
    chk(p, 48);
    period(1'b1, p);
    chk(p, 96);
    $display("test cpu halve done");
    for (k = 0; k < 4; k++) begin
      ctl = {16'h0, 1'b0, k[1:0], 5'h1, 4'h0, 2'h0, 2'h3};
      apb(1'b1, 32'h0, ctl, rd, err);
      period(1'b0, p);
      chk({30'h0, oscillator_band_select}, k);
      repeat (40) @(posedge ref_clk);
      if (k != 1) chk({31'h0, pll_locked}, {31'h0, k[1]});
      apb(1'b0, 32'h4, 32'h0, rd, err);
      chk(rd & 32'h32, {26'h0, k[1:0], 4'h2});
    end
    $display("test loop bands done");
    summarize();
  end
endmodule : master_clock_generator_bench
